// ===== hw/ise_defs.vh
// constants for the instruction subset execution block
// assumes a single clock domain and plain-port control, no register bus
`ifndef ISE_DEFS_VH
`define ISE_DEFS_VH

// opcode patterns
`define ISE_CLEAR_FILE_REGISTER_HI 7'b011_0101
`define ISE_RLNC_HI 6'b01_0001
`define ISE_RRC_HI 6'b00_1100
`define ISE_CLEAR_WATCHDOG_OP_OP 16'h0004
`define ISE_PROGRAM_STORE_WRITE_HI 14'h0003

// operand bit positions
`define ISE_BIT_A 8
`define ISE_BIT_D 9

// table pointer modes in the two low opcode bits
`define ISE_PM_KEEP 2'h0
`define ISE_PM_POSTINC 2'h1
`define ISE_PM_POSTDEC 2'h2
`define ISE_PM_PREINC 2'h3

// access bank split: low half in bank 0, high half in the top bank
`define ISE_ACC_SPLIT 8'h80
`define ISE_ACC_LO_BANK 4'h0
`define ISE_ACC_HI_BANK 4'hf

// widths and the holding register count
`define ISE_PTR_W 21
`define ISE_WDT_W 8
`define ISE_HOLD_N 8

// reset values and the watchdog top count
`define ISE_PTR_RST 21'h00_0000
`define ISE_BYTE_RST 8'h00
`define ISE_WDT_MAX 8'hff

// timing: quarter cycles per instruction cycle
`define ISE_QUARTERS 4

`endif

// ===== hw/ise_hold.v
// eight holding registers that stage bytes for program memory
// assumes the caller gives a one-cycle write strobe with index and data
`timescale 1ns/1ns
`include "ise_defs.vh"
module ise_hold (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [2:0] wr_index,
  input wire [7:0] wr_data,
  output wire [63:0] hold_flat
);

  // staging store, one byte per slot
  reg [7:0] hold_reg [0:`ISE_HOLD_N-1];

  genvar i;
  generate
    for (i = 0; i < `ISE_HOLD_N; i = i + 1) begin : g_slot
      // slot number at the index width, so the compare needs no genvar slice
      localparam [2:0] SLOT = i;
      // one slot: written only when its index is selected
      always @(posedge clk) begin
        if (rst) begin
          hold_reg[i] <= `ISE_BYTE_RST;
        end else if (wr_en && (wr_index == SLOT)) begin
          hold_reg[i] <= wr_data;
        end
      end
      assign hold_flat[8*i+7:8*i] = hold_reg[i];
    end
  endgenerate

endmodule // ise_hold

// ===== hw/ise_core.v
// executes a small instruction subset on a quarter-cycle sequencer
// assumes an external data file with one-cycle registered read
`timescale 1ns/1ns
`include "ise_defs.vh"
module ise_core (
  input wire clk,
  input wire rst,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [3:0] bank_select_register,
  input wire [7:0] file_rdata,
  input wire ptr_load,
  input wire [20:0] ptr_load_value,
  input wire latch_load,
  input wire [7:0] latch_load_value,
  input wire wdt_tick,
  input wire sleep_entered,
  output wire busy,
  output wire done,
  output wire illegal,
  output wire [11:0] file_addr,
  output wire file_re,
  output wire file_we,
  output wire [7:0] file_wdata,
  output wire [7:0] w_acc,
  output wire flag_c,
  output wire flag_z,
  output wire flag_n,
  output wire expiry_flag,
  output wire sleep_entry_flag,
  output wire [7:0] watchdog_counter,
  output wire [7:0] watchdog_post,
  output wire watchdog_expired,
  output wire [20:0] program_byte_pointer,
  output wire [7:0] program_byte_latch,
  output wire byte_is_high,
  output wire [63:0] hold_data
);

  // one-hot sequencer states
  localparam [4:0] ST_IDLE = 5'b0_0001;
  localparam [4:0] ST_Q1 = 5'b0_0010;
  localparam [4:0] ST_Q2 = 5'b0_0100;
  localparam [4:0] ST_Q3 = 5'b0_1000;
  localparam [4:0] ST_Q4 = 5'b1_0000;

  // one-hot operation codes
  localparam [5:0] OP_NONE = 6'b00_0001;
  localparam [5:0] OP_CLEAR_FILE_REGISTER = 6'b00_0010;
  localparam [5:0] OP_CLEAR_WATCHDOG_OP = 6'b00_0100;
  localparam [5:0] OP_RLNC = 6'b00_1000;
  localparam [5:0] OP_RRC = 6'b01_0000;
  localparam [5:0] OP_PROGRAM_STORE_WRITE = 6'b10_0000;

  // sequencer and instruction state
  reg [4:0] state_reg; // current quarter
  reg [15:0] ir_reg; // latched instruction word
  reg [5:0] op_reg; // decoded operation
  reg second_reg; // second instruction cycle of a store write
  reg busy_reg; // instruction in flight
  reg done_reg; // end-of-instruction pulse
  reg illegal_reg; // unsupported opcode pulse

  // data file access
  reg [11:0] addr_reg; // banked file address
  reg re_reg; // read strobe, high in the read quarter
  reg we_reg; // write strobe, high in the write quarter
  reg [7:0] wdata_reg; // write data

  // processing results
  reg [7:0] res_reg; // result byte
  reg res_c_reg; // pending carry
  reg to_file_reg; // result goes to the file
  reg [7:0] w_reg; // accumulator
  reg c_reg; // carry flag
  reg z_reg; // all-bits-clear flag
  reg n_reg; // result-msb flag

  // watchdog and power flags
  reg [7:0] wdt_reg; // watchdog count
  reg [7:0] post_reg; // postscaler count
  reg expired_reg; // time-out pulse
  reg expiry_reg; // time-out status, low after a time-out
  reg sleep_reg; // power-down status, low after sleep entry

  // table path
  reg [20:0] ptr_reg; // byte pointer into program memory
  reg [7:0] latch_reg; // byte latch
  reg [7:0] latch_cap_reg; // latch value read in the second cycle
  reg hold_we_reg; // holding register write strobe
  reg [2:0] hold_idx_reg; // holding register index

  // decode an instruction word into a one-hot operation
  function [5:0] decode_op;
    input [15:0] word;
    begin
      if (word[15:9] == `ISE_CLEAR_FILE_REGISTER_HI) begin
        decode_op = OP_CLEAR_FILE_REGISTER;
      end else if (word == `ISE_CLEAR_WATCHDOG_OP_OP) begin
        decode_op = OP_CLEAR_WATCHDOG_OP;
      end else if (word[15:10] == `ISE_RLNC_HI) begin
        decode_op = OP_RLNC;
      end else if (word[15:10] == `ISE_RRC_HI) begin
        decode_op = OP_RRC;
      end else if (word[15:2] == `ISE_PROGRAM_STORE_WRITE_HI) begin
        decode_op = OP_PROGRAM_STORE_WRITE;
      end else begin
        decode_op = OP_NONE;
      end
    end
  endfunction

  // form the banked address from the access bit, bank and offset
  function [11:0] bank_addr;
    input acc_n;
    input [3:0] bank;
    input [7:0] offs;
    begin
      if (acc_n) begin
        bank_addr = {bank, offs};
      end else if (offs < `ISE_ACC_SPLIT) begin
        bank_addr = {`ISE_ACC_LO_BANK, offs};
      end else begin
        bank_addr = {`ISE_ACC_HI_BANK, offs};
      end
    end
  endfunction

  // combinational decode of the latched word
  wire [5:0] op_dec = decode_op(ir_reg);
  wire [1:0] ptr_mode = ir_reg[1:0];
  wire is_tbl = (op_reg == OP_PROGRAM_STORE_WRITE);
  wire clear_watchdog_op_commit = (state_reg == ST_Q4) && (op_reg == OP_CLEAR_WATCHDOG_OP);

  // quarter-cycle sequencer and instruction datapath
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      ir_reg <= 16'h0000;
      op_reg <= OP_NONE;
      second_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      addr_reg <= 12'h000;
      re_reg <= 1'b0;
      we_reg <= 1'b0;
      wdata_reg <= 8'h00;
      res_reg <= 8'h00;
      res_c_reg <= 1'b0;
      to_file_reg <= 1'b0;
      w_reg <= 8'h00;
      c_reg <= 1'b0;
      z_reg <= 1'b0;
      n_reg <= 1'b0;
      ptr_reg <= `ISE_PTR_RST;
      latch_reg <= `ISE_BYTE_RST;
      latch_cap_reg <= `ISE_BYTE_RST;
      hold_we_reg <= 1'b0;
      hold_idx_reg <= 3'h0;
    end else begin
      // pulses default low
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // side loads of pointer and latch only between instructions
          if (ptr_load) begin
            ptr_reg <= ptr_load_value;
          end
          if (latch_load) begin
            latch_reg <= latch_load_value;
          end
          if (instr_valid) begin
            ir_reg <= instr_word;
            busy_reg <= 1'b1;
            second_reg <= 1'b0;
            state_reg <= ST_Q1;
          end
        end
        ST_Q1: begin
          // decode and present the file address
          op_reg <= op_dec;
          addr_reg <= bank_addr(ir_reg[`ISE_BIT_A], bank_select_register, ir_reg[7:0]);
          if (!second_reg && ((op_dec == OP_CLEAR_FILE_REGISTER) || (op_dec == OP_RLNC) ||
              (op_dec == OP_RRC))) begin
            re_reg <= 1'b1;
          end
          state_reg <= ST_Q2;
        end
        ST_Q2: begin
          // file read quarter; store write reads the latch here
          re_reg <= 1'b0;
          if (is_tbl && second_reg) begin
            latch_cap_reg <= latch_reg;
          end
          state_reg <= ST_Q3;
        end
        ST_Q3: begin
          // process the data read in the previous quarter
          case (op_reg)
            OP_CLEAR_FILE_REGISTER: begin
              res_reg <= 8'h00;
              to_file_reg <= 1'b1;
              wdata_reg <= 8'h00;
              we_reg <= 1'b1;
            end
            OP_RLNC: begin
              res_reg <= {file_rdata[6:0], file_rdata[7]};
              to_file_reg <= ir_reg[`ISE_BIT_D];
              wdata_reg <= {file_rdata[6:0], file_rdata[7]};
              we_reg <= ir_reg[`ISE_BIT_D];
            end
            OP_RRC: begin
              res_reg <= {c_reg, file_rdata[7:1]};
              res_c_reg <= file_rdata[0];
              to_file_reg <= ir_reg[`ISE_BIT_D];
              wdata_reg <= {c_reg, file_rdata[7:1]};
              we_reg <= ir_reg[`ISE_BIT_D];
            end
            OP_PROGRAM_STORE_WRITE: begin
              // strobe the holding write in the last quarter of cycle two
              if (second_reg) begin
                hold_idx_reg <= ptr_reg[2:0];
                hold_we_reg <= 1'b1;
              end
            end
            default: begin
              to_file_reg <= 1'b0;
            end
          endcase
          state_reg <= ST_Q4;
        end
        ST_Q4: begin
          // write quarter: the file write lands on this edge
          we_reg <= 1'b0;
          hold_we_reg <= 1'b0;
          case (op_reg)
            OP_CLEAR_FILE_REGISTER: begin
              z_reg <= 1'b1;
            end
            OP_RLNC: begin
              if (!to_file_reg) begin
                w_reg <= res_reg;
              end
              n_reg <= res_reg[7];
              z_reg <= (res_reg == 8'h00);
            end
            OP_RRC: begin
              if (!to_file_reg) begin
                w_reg <= res_reg;
              end
              c_reg <= res_c_reg;
              n_reg <= res_reg[7];
              z_reg <= (res_reg == 8'h00);
            end
            OP_PROGRAM_STORE_WRITE: begin
              // pointer moves one byte either side of the holding write; keep mode leaves it unchanged
              if (!second_reg && (ptr_mode == `ISE_PM_PREINC)) begin
                ptr_reg <= ptr_reg + 21'h00_0001;
              end else if (second_reg && (ptr_mode == `ISE_PM_POSTINC)) begin
                ptr_reg <= ptr_reg + 21'h00_0001;
              end else if (second_reg && (ptr_mode == `ISE_PM_POSTDEC)) begin
                ptr_reg <= ptr_reg - 21'h00_0001;
              end
            end
            OP_NONE: begin
              illegal_reg <= 1'b1;
            end
            default: begin
              illegal_reg <= 1'b0;
            end
          endcase
          if (is_tbl && !second_reg) begin
            second_reg <= 1'b1;
            state_reg <= ST_Q1;
          end else begin
            second_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // watchdog counter with postscaler; clearing wins over a tick
  always @(posedge clk) begin
    if (rst) begin
      wdt_reg <= 8'h00;
      post_reg <= 8'h00;
      expired_reg <= 1'b0;
    end else if (clear_watchdog_op_commit) begin
      wdt_reg <= 8'h00;
      post_reg <= 8'h00;
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= 1'b0;
      if (wdt_tick) begin
        post_reg <= post_reg + 8'h01;
        if (post_reg == `ISE_WDT_MAX) begin
          wdt_reg <= wdt_reg + 8'h01;
          if (wdt_reg == `ISE_WDT_MAX) begin
            expired_reg <= 1'b1;
          end
        end
      end
    end
  end

  // status flags: clear-watchdog sets, time-out or sleep clears
  always @(posedge clk) begin
    if (rst) begin
      expiry_reg <= 1'b1;
      sleep_reg <= 1'b1;
    end else begin
      if (clear_watchdog_op_commit) begin
        expiry_reg <= 1'b1;
      end else if (expired_reg) begin
        expiry_reg <= 1'b0;
      end
      if (clear_watchdog_op_commit) begin
        sleep_reg <= 1'b1;
      end else if (sleep_entered) begin
        sleep_reg <= 1'b0;
      end
    end
  end

  // holding register bank
  ise_hold u_hold (
    .clk(clk),
    .rst(rst),
    .wr_en(hold_we_reg),
    .wr_index(hold_idx_reg),
    .wr_data(latch_cap_reg),
    .hold_flat(hold_data)
  );

  // outputs straight from flip-flops
  assign busy = busy_reg;
  assign done = done_reg;
  assign illegal = illegal_reg;
  assign file_addr = addr_reg;
  assign file_re = re_reg;
  assign file_we = we_reg;
  assign file_wdata = wdata_reg;
  assign w_acc = w_reg;
  assign flag_c = c_reg;
  assign flag_z = z_reg;
  assign flag_n = n_reg;
  assign expiry_flag = expiry_reg;
  assign sleep_entry_flag = sleep_reg;
  assign watchdog_counter = wdt_reg;
  assign watchdog_post = post_reg;
  assign watchdog_expired = expired_reg;
  assign program_byte_pointer = ptr_reg;
  assign program_byte_latch = latch_reg;
  assign byte_is_high = ptr_reg[0];

endmodule // ise_core

// ===== dv/ise_file_model.sv
// data file model facing the core's file port
// assumes one clock, one-cycle read and write strobes from the core
`timescale 1ns/1ns
module ise_file_model (
  input logic clk,
  input logic re,
  input logic we,
  input logic [11:0] addr,
  input logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:4095]; // banked data registers
  initial rdata = 8'h00;
  // write on strobe; read lands next cycle, junk when not read
  always @(posedge clk) begin
    if (we) mem[addr] <= wdata;
    rdata <= re ? mem[addr] : ~rdata;
  end
endmodule // ise_file_model

// ===== dv/ise_core_chk.sv
// assertions on the ports of the instruction subset core
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module ise_core_chk (
  input logic clk,
  input logic rst,
  input logic instr_valid,
  input logic [15:0] instr_word,
  input logic [3:0] bank_select_register,
  input logic [7:0] file_rdata,
  input logic busy,
  input logic done,
  input logic [11:0] file_addr,
  input logic file_re,
  input logic file_we,
  input logic [7:0] file_wdata,
  input logic [7:0] w_acc,
  input logic flag_c,
  input logic flag_z,
  input logic flag_n,
  input logic expiry_flag,
  input logic sleep_entry_flag,
  input logic [7:0] watchdog_counter,
  input logic [7:0] watchdog_post
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = instr_valid && !busy; // instruction taken
  wire tbl = instr_word[15:2] == 14'h0003; // store write
  wire clr = instr_word[15:9] == 7'h35; // clear register
  wire rl = instr_word[15:10] == 6'h11; // rotate left
  wire rr = instr_word[15:10] == 6'h0c; // rotate right
  wire dbit = instr_word[9]; // destination bit
  wire [2:0] flags = {flag_c, flag_z, flag_n};
  wire [7:0] rol = {file_rdata[6:0], file_rdata[7]};
  wire [8:0] ror = {file_rdata[0], flag_c, file_rdata[7:1]};
  // expected file address from the access bit
  wire [11:0] ea = instr_word[8] ? {bank_select_register, instr_word[7:0]} :
    {instr_word[7] ? 4'hf : 4'h0, instr_word[7:0]};
  // four busy quarters then done
  sequence s_one;
    ##1 busy [*4] ##1 (done && !busy);
  endsequence
  // two instruction cycles then done
  sequence s_two;
    ##1 busy [*8] ##1 (done && !busy);
  endsequence
  a_quarter_timing: assert property (tk && !tbl |-> s_one)
    else $error("single-cycle op timing wrong");
  a_store_two_cycle: assert property (tk && tbl |-> s_two)
    else $error("store write not two cycles");
  a_store_no_flags: assert property (tk && tbl |-> ##9 flags == $past(flags, 9))
    else $error("store write changed flags");
  a_clear_writes_zero: assert property (tk && clr |->
    ##4 (file_we && file_wdata == 8'h00) ##1 flag_z)
    else $error("clear did not write zero");
  a_dest_select: assert property (tk && (rl || rr) |-> ##4 file_we == $past(dbit, 4))
    else $error("destination select wrong");
  a_rotate_left: assert property (tk && rl && dbit |-> ##4 file_wdata == $past(rol))
    else $error("rotate left result wrong");
  a_rotate_right: assert property (tk && rr && !dbit |->
    ##5 {flag_c, w_acc} == $past(ror, 2))
    else $error("rotate right result wrong");
  a_access_bank: assert property (tk && (clr || rl || rr) |->
    ##2 (file_re && file_addr == $past(ea, 2)))
    else $error("file address wrong");
  a_watchdog_clear: assert property (tk && instr_word == 16'h0004 |-> ##5 (done &&
    watchdog_counter == 8'h00 && watchdog_post == 8'h00 && expiry_flag && sleep_entry_flag))
    else $error("watchdog clear wrong");
endmodule // ise_core_chk
bind ise_core ise_core_chk u_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .bank_select_register(bank_select_register),
  .file_rdata(file_rdata), .busy(busy), .done(done), .file_addr(file_addr),
  .file_re(file_re), .file_we(file_we), .file_wdata(file_wdata), .w_acc(w_acc),
  .flag_c(flag_c), .flag_z(flag_z), .flag_n(flag_n), .expiry_flag(expiry_flag),
  .sleep_entry_flag(sleep_entry_flag), .watchdog_counter(watchdog_counter),
  .watchdog_post(watchdog_post));

// ===== dv/test_instr_subset_exec.sv
// self-checking bench for the instruction subset core
// assumes core, file model and checker are compiled first
`timescale 1ns/1ns
module test_instr_subset_exec;
  logic clk = 1'b0;
  logic rst = 1'b1; // held for eight cycles
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_register = 4'h3; // bank used when access bit is 1
  logic ptr_load = 1'b0;
  logic [20:0] ptr_load_value = 21'h00_0000;
  logic latch_load = 1'b0;
  logic [7:0] latch_load_value = 8'h00;
  logic wdt_tick = 1'b0;
  logic sleep_entered = 1'b0;
  logic busy, done, file_re, file_we, flag_c, flag_z, flag_n;
  logic expiry_flag, sleep_entry_flag, byte_is_high;
  logic [11:0] file_addr;
  logic [7:0] file_rdata, file_wdata, w_acc, watchdog_counter, watchdog_post;
  logic [7:0] program_byte_latch;
  logic [20:0] program_byte_pointer;
  logic [63:0] hold_data;
  int n_errors = 0;
  int comparisons = 0;
  int n; // cycles from take to done
  // word, address, source, result, {c,n,z}
  logic [46:0] rows [8] = '{{16'h6a90, 12'hf90, 8'h5a, 8'h00, 3'h1},
    {16'h6b10, 12'h310, 8'hff, 8'h00, 3'h1}, {16'h4722, 12'h322, 8'hab, 8'h57, 3'h0},
    {16'h4405, 12'h005, 8'h80, 8'h01, 3'h0}, {16'h307f, 12'h07f, 8'he6, 8'h73, 3'h0},
    {16'h3344, 12'h344, 8'h01, 8'h00, 3'h5}, {16'h3144, 12'h344, 8'h00, 8'h80, 3'h2},
    {16'h4681, 12'hf81, 8'h40, 8'h80, 3'h2}};
  // start and final pointer per store mode
  logic [20:0] bases [4] = '{21'h1f_ffff, 21'h00_a356, 21'h00_0000, 21'h01_389a};
  logic [20:0] fin [4] = '{21'h1f_ffff, 21'h00_a357, 21'h1f_ffff, 21'h01_389b};
  logic [15:0] w;
  logic [11:0] a;
  logic [7:0] s, r;
  logic [2:0] f, fl, idx;
  always #5 clk = ~clk;
  ise_core u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .bank_select_register(bank_select_register), .file_rdata(file_rdata),
    .ptr_load(ptr_load), .ptr_load_value(ptr_load_value), .latch_load(latch_load),
    .latch_load_value(latch_load_value), .wdt_tick(wdt_tick), .sleep_entered(sleep_entered),
    .busy(busy), .done(done), .illegal(), .file_addr(file_addr), .file_re(file_re),
    .file_we(file_we), .file_wdata(file_wdata), .w_acc(w_acc), .flag_c(flag_c),
    .flag_z(flag_z), .flag_n(flag_n), .expiry_flag(expiry_flag),
    .sleep_entry_flag(sleep_entry_flag), .watchdog_counter(watchdog_counter),
    .watchdog_post(watchdog_post), .watchdog_expired(), .hold_data(hold_data),
    .program_byte_pointer(program_byte_pointer), .byte_is_high(byte_is_high),
    .program_byte_latch(program_byte_latch));
  ise_file_model u_mem (.clk(clk), .re(file_re), .we(file_we), .addr(file_addr),
    .wdata(file_wdata), .rdata(file_rdata));
  // compare and count
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  // issue one instruction, count cycles until done
  task run(input logic [15:0] word);
    instr_valid = 1'b1;
    instr_word = word;
    @(posedge clk) #1;
    instr_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk({expiry_flag, sleep_entry_flag, w_acc, program_byte_pointer}, 31'h6000_0000);
    chk(hold_data, 64'h0);
    $display("test reset done");
    // back to back register ops, each preloading its source
    foreach (rows[i]) begin
      {w, a, s, r, f} = rows[i];
      u_mem.mem[a] = s;
      run(w);
      chk(n, 4);
      chk(w[9] ? u_mem.mem[a] : w_acc, r);
      chk({flag_c, flag_n, flag_z}, f);
    end
    $display("test register ops done");
    // run the watchdog up, then clear it
    wdt_tick = 1'b1;
    repeat (260) @(posedge clk);
    #1 wdt_tick = 1'b0;
    // sleep entry drops the power-down flag; the clear must raise it again
    sleep_entered = 1'b1;
    @(posedge clk) #1;
    sleep_entered = 1'b0;
    chk(sleep_entry_flag, 1'b0);
    run(16'h0004);
    chk(n, 4);
    chk({watchdog_counter, watchdog_post, expiry_flag, sleep_entry_flag}, 18'h0_0003);
    $display("test watchdog clear done");
    // every pointer mode, including post-decrement wrap below zero
    for (int m = 0; m < 4; m++) begin
      ptr_load = 1'b1;
      ptr_load_value = bases[m];
      latch_load = 1'b1;
      latch_load_value = {6'h14, m[1:0]};
      @(posedge clk) #1;
      ptr_load = 1'b0;
      latch_load = 1'b0;
      idx = (m == 3) ? fin[m][2:0] : bases[m][2:0];
      fl = {flag_c, flag_n, flag_z};
      run({14'h0003, m[1:0]});
      chk(n, 8);
      chk(hold_data[{idx, 3'h0} +: 8], {6'h14, m[1:0]});
      chk(program_byte_pointer, fin[m]);
      chk(byte_is_high, fin[m][0]);
      chk({flag_c, flag_n, flag_z}, fl);
    end
    $display("test store write done");
    test_done;
  end
  // run needs under 500 cycles; cut off far beyond
  initial begin
    #20000;
    n_errors++;
    test_done;
  end
endmodule // test_instr_subset_exec
